// file: core/pmdi_phy_end.sv
`timescale 1ns/1ps
module pmdi_phy_end (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire pmdi_pkg::pmdi_mode_e  mode_i,
    input  wire logic                  half_duplex_i,
    pmdi_link_if.phy_mp                link,
    input  wire logic [7:0]            rx_data_i,
    input  wire logic                  rx_err_i,
    input  wire logic                  rx_valid_i,
    output logic                       rx_ready_o,
    output logic [7:0]                 tx_data_o,
    output pmdi_pkg::pmdi_sym_e        tx_sym_o,
    output logic                       tx_valid_o
);
    import pmdi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Link clock divider shared by the MII transmit clock and the receive clock.
    logic [DIV_W-1:0] div_cnt_r;
    logic [DIV_W-1:0] half_cyc;
    logic             lclk_r;
    logic             wrap;
    logic             tick_rise;
    logic             tick_fall;
    logic             is_mii;
    logic             is_rgmii;
    logic             tx_clk_r;
    logic             rx_clk_r;

    assign is_mii   = (mode_i == PMDI_MODE_MII10) || (mode_i == PMDI_MODE_MII100);
    assign is_rgmii = (mode_i == PMDI_MODE_RGMII);

    always_comb begin
        unique case (mode_i)
            PMDI_MODE_MII10:  half_cyc = DIV_W'(HALF10_CYC);
            PMDI_MODE_MII100: half_cyc = DIV_W'(HALF100_CYC);
            default:          half_cyc = DIV_W'(HALFGIG_CYC);
        endcase
    end

    assign wrap      = (div_cnt_r >= half_cyc - DIV_W'(1));
    assign tick_rise = wrap & ~lclk_r;
    assign tick_fall = wrap & lclk_r;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            div_cnt_r <= '0;
            lclk_r    <= 1'b0;
            tx_clk_r  <= 1'b0;
            rx_clk_r  <= 1'b0;
        end else if (wrap) begin
            div_cnt_r <= '0;
            lclk_r    <= ~lclk_r;
            tx_clk_r  <= is_mii & ~lclk_r;
            rx_clk_r  <= ~is_rgmii & ~lclk_r;
        end else begin
            div_cnt_r <= div_cnt_r + DIV_W'(1);
        end
    end

    assign link.tx_clk = tx_clk_r;
    assign link.rx_clk = rx_clk_r;

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry receive buffer between the media side and the link.
    logic [8:0] rbuf_r [BUF_DEPTH];
    logic       rwr_ptr_r;
    logic       rrd_ptr_r;
    logic [1:0] rcnt_r;
    logic [1:0] rcnt_nxt;
    logic       push;
    logic       pop;
    logic       rx_ready_r;
    logic       rx_phase_r;

    assign push = rx_valid_i & rx_ready_r;
    assign pop  = tick_rise & (rcnt_r != 2'h0) & ~(is_mii & rx_phase_r);

    always_comb begin
        rcnt_nxt = rcnt_r;
        if (push && !pop) begin
            rcnt_nxt = rcnt_r + 2'h1;
        end else if (pop && !push) begin
            rcnt_nxt = rcnt_r - 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rwr_ptr_r  <= 1'b0;
            rrd_ptr_r  <= 1'b0;
            rcnt_r     <= 2'h0;
            rx_ready_r <= 1'b0;
        end else begin
            rcnt_r     <= rcnt_nxt;
            rx_ready_r <= (rcnt_nxt != 2'(BUF_DEPTH));
            if (push) begin
                rwr_ptr_r <= ~rwr_ptr_r;
            end
            if (pop) begin
                rrd_ptr_r <= ~rrd_ptr_r;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            rbuf_r[rwr_ptr_r] <= {rx_err_i, rx_data_i};
        end
    end

    assign rx_ready_o = rx_ready_r;

    ////////////////////////////////////////////////////////////////////////////
    // Receive link driver.
    logic [7:0] rxd_r;
    logic       rx_dv_r;
    logic       rx_er_r;
    logic [8:0] rhold_r;
    logic       rvalid_r;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rxd_r      <= 8'h00;
            rx_dv_r    <= 1'b0;
            rx_er_r    <= 1'b0;
            rhold_r    <= 9'h000;
            rvalid_r   <= 1'b0;
            rx_phase_r <= 1'b0;
        end else if (is_rgmii) begin
            rx_phase_r <= 1'b0;
            if (wrap) begin
                rx_dv_r <= ~lclk_r;
            end
            if (tick_rise) begin
                rvalid_r <= pop;
                rhold_r  <= rbuf_r[rrd_ptr_r];
                rxd_r    <= {4'h0, rbuf_r[rrd_ptr_r][3:0] & {4{pop}}};
                rx_er_r  <= pop;
            end else if (tick_fall) begin
                rxd_r    <= {4'h0, rhold_r[7:4] & {4{rvalid_r}}};
                rx_er_r  <= rvalid_r ^ (rvalid_r & rhold_r[8]);
            end
        end else if (tick_rise) begin
            if (is_mii && rx_phase_r) begin
                rxd_r      <= {4'h0, rhold_r[7:4]};
                rx_phase_r <= 1'b0;
            end else if (pop) begin
                rhold_r <= rbuf_r[rrd_ptr_r];
                rx_dv_r <= 1'b1;
                rx_er_r <= rbuf_r[rrd_ptr_r][8];
                if (is_mii) begin
                    rxd_r      <= {4'h0, rbuf_r[rrd_ptr_r][3:0]};
                    rx_phase_r <= 1'b1;
                end else begin
                    rxd_r <= rbuf_r[rrd_ptr_r][7:0];
                end
            end else begin
                rxd_r   <= 8'h00;
                rx_dv_r <= 1'b0;
                rx_er_r <= 1'b0;
            end
        end
    end

    assign link.rxd   = rxd_r;
    assign link.rx_dv = rx_dv_r;
    assign link.rx_er = rx_er_r;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit link sampler: MII on its own clock, GMII and RGMII on the MAC clock.
    logic       tx_clk_prev_r;
    logic       gtx_prev_r;
    logic       mii_rise;
    logic       g_rise;
    logic       g_fall;
    logic       tx_phase_r;
    logic [3:0] tlow_r;
    logic       ten_rise_r;
    pmdi_txe_e  txe_r;
    logic [7:0] tx_data_r;
    pmdi_sym_e  tx_sym_r;
    logic       tx_valid_r;

    assign mii_rise = is_mii & tx_clk_r & ~tx_clk_prev_r;
    assign g_rise   = ~is_mii & link.gtx_clk & ~gtx_prev_r;
    assign g_fall   = is_rgmii & ~link.gtx_clk & gtx_prev_r;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_clk_prev_r <= 1'b0;
            gtx_prev_r    <= 1'b0;
        end else begin
            tx_clk_prev_r <= tx_clk_r;
            gtx_prev_r    <= link.gtx_clk;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            txe_r      <= PMDI_TXE_NORMAL;
            tx_phase_r <= 1'b0;
            tlow_r     <= 4'h0;
            ten_rise_r <= 1'b0;
            tx_data_r  <= 8'h00;
            tx_sym_r   <= PMDI_SYM_DATA;
            tx_valid_r <= 1'b0;
        end else begin
            tx_valid_r <= 1'b0;
            if (mii_rise) begin
                unique case (txe_r)
                    PMDI_TXE_NORMAL: begin
                        if (link.tx_er) begin
                            txe_r      <= PMDI_TXE_INVALID;
                            tx_sym_r   <= PMDI_SYM_INVALID;
                            tx_valid_r <= 1'b1;
                            tx_phase_r <= 1'b0;
                        end else if (link.tx_en) begin
                            tx_phase_r <= ~tx_phase_r;
                            tlow_r     <= link.txd[3:0];
                            if (tx_phase_r) begin
                                tx_data_r  <= {link.txd[3:0], tlow_r};
                                tx_sym_r   <= PMDI_SYM_DATA;
                                tx_valid_r <= 1'b1;
                            end
                        end else begin
                            tx_phase_r <= 1'b0;
                        end
                    end
                    PMDI_TXE_INVALID, PMDI_TXE_HALT: begin
                        if (link.tx_er) begin
                            txe_r      <= PMDI_TXE_HALT;
                            tx_sym_r   <= PMDI_SYM_HALT;
                            tx_valid_r <= 1'b1;
                        end else begin
                            txe_r      <= PMDI_TXE_NORMAL;
                            tx_phase_r <= link.tx_en;
                            tlow_r     <= link.txd[3:0];
                        end
                    end
                endcase
            end else if (g_rise) begin
                txe_r <= PMDI_TXE_NORMAL;
                if (is_rgmii) begin
                    tlow_r     <= link.txd[3:0];
                    ten_rise_r <= link.tx_en;
                end else if (link.tx_er) begin
                    tx_sym_r   <= PMDI_SYM_INVALID;
                    tx_valid_r <= 1'b1;
                end else if (link.tx_en) begin
                    tx_data_r  <= link.txd;
                    tx_sym_r   <= PMDI_SYM_DATA;
                    tx_valid_r <= 1'b1;
                end
            end else if (g_fall && ten_rise_r) begin
                // The dedicated error pin is not looked at here.
                tx_data_r  <= {link.txd[3:0], tlow_r};
                tx_sym_r   <= (link.tx_en ^ ten_rise_r) ? PMDI_SYM_INVALID : PMDI_SYM_DATA;
                tx_valid_r <= 1'b1;
            end
        end
    end

    assign tx_data_o  = tx_data_r;
    assign tx_sym_o   = tx_sym_r;
    assign tx_valid_o = tx_valid_r;

    ////////////////////////////////////////////////////////////////////////////
    // Collision indication, not aligned to any link clock.
    logic col_r;
    logic tx_busy;

    assign tx_busy = is_rgmii ? ten_rise_r : link.tx_en;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            col_r <= 1'b0;
        end else begin
            col_r <= half_duplex_i & tx_busy & ((rcnt_r != 2'h0) | rx_phase_r);
        end
    end

    assign link.col = col_r;

endmodule // pmdi_phy_end

// file: core/pmdi_pkg.sv
// Notes on behaviour
// - MII transmit data is a clocked nibble.
// - GMII transmit data is a byte per clock.
// - RGMII transmit uses the low nibble only.
// - MAC holds transmit enable during valid data.
// - RGMII transmit control carries enable and error.
// - MAC runs the gigabit transmit clock continuously.
// - MII transmit error gives invalid, then halt symbols.
// - GMII transmit error inserts an invalid code-group.
// - PHY ignores transmit error pin in RGMII.
// - PHY drives receive clock, unused in RGMII.
// - Receive data is nibble in MII, byte in GMII.
// - RGMII receive data uses the low nibble.
// - PHY raises receive error on stream errors.
// - RGMII receive control carries valid and error.
// - Receive data valid marks exactly the valid data; in RGMII the PHY toggles it every cycle as the receive clock.
// - Receive valid pin carries the RGMII receive clock.
// - PHY drives the MII transmit clock continuously.
// - Collision flags simultaneous activity in half duplex.
package pmdi_pkg;

    typedef enum logic [1:0] {
        PMDI_MODE_MII10  = 2'h0,
        PMDI_MODE_MII100 = 2'h1,
        PMDI_MODE_GMII   = 2'h2,
        PMDI_MODE_RGMII  = 2'h3
    } pmdi_mode_e;

    // Symbol class handed to the media side.
    typedef enum logic [1:0] {
        PMDI_SYM_DATA    = 2'h0,
        PMDI_SYM_INVALID = 2'h1,
        PMDI_SYM_HALT    = 2'h2
    } pmdi_sym_e;

    typedef enum logic [2:0] {
        PMDI_TXE_NORMAL  = 3'h1,
        PMDI_TXE_INVALID = 3'h2,
        PMDI_TXE_HALT    = 3'h4
    } pmdi_txe_e;

    localparam int CLK_PERIOD_NS    = 20;
    localparam int MII10_PERIOD_NS  = 400;
    localparam int MII100_PERIOD_NS = 40;
    localparam int GIG_PERIOD_NS    = 8;

    // Half periods of the link clocks in system clocks, never below one.
    localparam int HALF10_CYC  = (MII10_PERIOD_NS / 2 / CLK_PERIOD_NS < 1) ? 1
                                : MII10_PERIOD_NS / 2 / CLK_PERIOD_NS;
    localparam int HALF100_CYC = (MII100_PERIOD_NS / 2 / CLK_PERIOD_NS < 1) ? 1
                                : MII100_PERIOD_NS / 2 / CLK_PERIOD_NS;
    localparam int HALFGIG_CYC = (GIG_PERIOD_NS / 2 / CLK_PERIOD_NS < 1) ? 1
                                : GIG_PERIOD_NS / 2 / CLK_PERIOD_NS;

    localparam int DIV_W      = 4;
    localparam int BUF_DEPTH  = 2;
    localparam int DATA_W     = 8;
    localparam int NIB_W      = 4;

endpackage

// file: core/pmdi_link_if.sv
`timescale 1ns/1ps
interface pmdi_link_if;
    logic [7:0] txd;
    logic       tx_en;
    logic       tx_er;
    logic       gtx_clk;
    logic       tx_clk;
    logic       rx_clk;
    logic [7:0] rxd;
    logic       rx_dv;
    logic       rx_er;
    logic       col;

    modport phy_mp (
        input  txd, tx_en, tx_er, gtx_clk,
        output tx_clk, rx_clk, rxd, rx_dv, rx_er, col
    );
    modport mac_mp (
        output txd, tx_en, tx_er, gtx_clk,
        input  tx_clk, rx_clk, rxd, rx_dv, rx_er, col
    );
endinterface

// file: core/pmdi_mac_end.sv
`timescale 1ns/1ps
module pmdi_mac_end (
    input  wire logic                  clk_i,
    input  wire logic                  srst_i,
    input  wire pmdi_pkg::pmdi_mode_e  mode_i,
    pmdi_link_if.mac_mp                link,
    input  wire logic [7:0]            tx_data_i,
    input  wire logic                  tx_err_i,
    input  wire logic                  tx_valid_i,
    output logic                       tx_ready_o,
    output logic [7:0]                 rx_data_o,
    output logic                       rx_err_o,
    output logic                       rx_valid_o,
    output logic                       col_o
);
    import pmdi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Gigabit transmit clock, running continuously in GMII and RGMII.
    logic [DIV_W-1:0] gdiv_r;
    logic             gclk_r;
    logic             gwrap;
    logic             is_mii;
    logic             is_rgmii;

    assign is_mii   = (mode_i == PMDI_MODE_MII10) || (mode_i == PMDI_MODE_MII100);
    assign is_rgmii = (mode_i == PMDI_MODE_RGMII);
    assign gwrap    = ~is_mii & (gdiv_r >= DIV_W'(HALFGIG_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (srst_i || is_mii) begin
            gdiv_r <= '0;
            gclk_r <= 1'b0;
        end else if (gwrap) begin
            gdiv_r <= '0;
            gclk_r <= ~gclk_r;
        end else begin
            gdiv_r <= gdiv_r + DIV_W'(1);
        end
    end

    assign link.gtx_clk = gclk_r;

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry transmit buffer.
    logic [8:0] tbuf_r [BUF_DEPTH];
    logic       twr_ptr_r;
    logic       trd_ptr_r;
    logic [1:0] tcnt_r;
    logic [1:0] tcnt_nxt;
    logic       tready_r;
    logic       push;
    logic       pop;
    logic       tphase_r;
    logic       txc_prev_r;
    logic       mii_fall;
    logic       g_rise;

    assign mii_fall = is_mii & ~link.tx_clk & txc_prev_r;
    assign g_rise   = gwrap & ~gclk_r;
    assign push     = tx_valid_i & tready_r;
    assign pop      = (tcnt_r != 2'h0) & ((mii_fall & ~tphase_r) | g_rise);

    always_comb begin
        tcnt_nxt = tcnt_r;
        if (push && !pop) begin
            tcnt_nxt = tcnt_r + 2'h1;
        end else if (pop && !push) begin
            tcnt_nxt = tcnt_r - 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            twr_ptr_r  <= 1'b0;
            trd_ptr_r  <= 1'b0;
            tcnt_r     <= 2'h0;
            tready_r   <= 1'b0;
            txc_prev_r <= 1'b0;
        end else begin
            tcnt_r     <= tcnt_nxt;
            tready_r   <= (tcnt_nxt != 2'(BUF_DEPTH));
            txc_prev_r <= link.tx_clk;
            if (push) begin
                twr_ptr_r <= ~twr_ptr_r;
            end
            if (pop) begin
                trd_ptr_r <= ~trd_ptr_r;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            tbuf_r[twr_ptr_r] <= {tx_err_i, tx_data_i};
        end
    end

    assign tx_ready_o = tready_r;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit link driver.
    logic [7:0] txd_r;
    logic       ten_r;
    logic       ter_r;
    logic [8:0] thold_r;
    logic       tval_r;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            txd_r    <= 8'h00;
            ten_r    <= 1'b0;
            ter_r    <= 1'b0;
            thold_r  <= 9'h000;
            tval_r   <= 1'b0;
            tphase_r <= 1'b0;
        end else if (mii_fall) begin
            if (tphase_r) begin
                txd_r    <= {4'h0, thold_r[7:4]};
                tphase_r <= 1'b0;
            end else begin
                thold_r  <= tbuf_r[trd_ptr_r];
                txd_r    <= {4'h0, tbuf_r[trd_ptr_r][3:0] & {4{pop}}};
                ten_r    <= pop;
                ter_r    <= pop & tbuf_r[trd_ptr_r][8];
                tphase_r <= pop;
            end
        end else if (g_rise) begin
            tphase_r <= 1'b0;
            tval_r   <= pop;
            thold_r  <= tbuf_r[trd_ptr_r];
            ten_r    <= pop;
            if (is_rgmii) begin
                txd_r <= {4'h0, tbuf_r[trd_ptr_r][3:0] & {4{pop}}};
                ter_r <= 1'b0;
            end else begin
                txd_r <= tbuf_r[trd_ptr_r][7:0] & {8{pop}};
                ter_r <= pop & tbuf_r[trd_ptr_r][8];
            end
        end else if (gwrap && is_rgmii) begin
            txd_r <= {4'h0, thold_r[7:4] & {4{tval_r}}};
            ten_r <= tval_r ^ (tval_r & thold_r[8]);
        end
    end

    assign link.txd   = txd_r;
    assign link.tx_en = ten_r;
    assign link.tx_er = ter_r;

    ////////////////////////////////////////////////////////////////////////////
    // Receive sampler: RX clock pin in MII and GMII, valid pin as clock in RGMII.
    logic       rclk_prev_r;
    logic       rcv_prev_r;
    logic       r_rise;
    logic       rg_rise;
    logic       rg_fall;
    logic       rphase_r;
    logic [3:0] rlow_r;
    logic       rdv_rise_r;
    logic [7:0] rx_data_r;
    logic       rx_err_r;
    logic       rx_valid_r;
    logic       col_r;

    assign r_rise  = ~is_rgmii & link.rx_clk & ~rclk_prev_r;
    assign rg_rise = is_rgmii & link.rx_dv & ~rcv_prev_r;
    assign rg_fall = is_rgmii & ~link.rx_dv & rcv_prev_r;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rclk_prev_r <= 1'b0;
            rcv_prev_r  <= 1'b0;
            col_r       <= 1'b0;
        end else begin
            rclk_prev_r <= link.rx_clk;
            rcv_prev_r  <= link.rx_dv;
            col_r       <= link.col;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rphase_r   <= 1'b0;
            rlow_r     <= 4'h0;
            rdv_rise_r <= 1'b0;
            rx_data_r  <= 8'h00;
            rx_err_r   <= 1'b0;
            rx_valid_r <= 1'b0;
        end else begin
            rx_valid_r <= 1'b0;
            if (r_rise) begin
                if (!link.rx_dv) begin
                    rphase_r <= 1'b0;
                end else if (!is_mii) begin
                    rx_data_r  <= link.rxd;
                    rx_err_r   <= link.rx_er;
                    rx_valid_r <= 1'b1;
                end else if (rphase_r) begin
                    rx_data_r  <= {link.rxd[3:0], rlow_r};
                    rx_err_r   <= rx_err_r | link.rx_er;
                    rx_valid_r <= 1'b1;
                    rphase_r   <= 1'b0;
                end else begin
                    rlow_r   <= link.rxd[3:0];
                    rx_err_r <= link.rx_er;
                    rphase_r <= 1'b1;
                end
            end else if (rg_rise) begin
                rlow_r     <= link.rxd[3:0];
                rdv_rise_r <= link.rx_er;
            end else if (rg_fall && rdv_rise_r) begin
                rx_data_r  <= {link.rxd[3:0], rlow_r};
                rx_err_r   <= link.rx_er ^ rdv_rise_r;
                rx_valid_r <= 1'b1;
            end
        end
    end

    assign rx_data_o  = rx_data_r;
    assign rx_err_o   = rx_err_r;
    assign rx_valid_o = rx_valid_r;
    assign col_o      = col_r;

endmodule // pmdi_mac_end

// file: tb/pmdi_props.sv
`timescale 1ns/1ps
module pmdi_props (
    input wire logic                 clk_i,
    input wire logic                 srst_i,
    input wire pmdi_pkg::pmdi_mode_e mode_i,
    input wire logic                 half_duplex_i,
    input wire logic [7:0]           txd,
    input wire logic                 tx_er,
    input wire logic                 gtx_clk,
    input wire logic                 tx_clk,
    input wire logic                 rx_clk,
    input wire logic [7:0]           rxd,
    input wire logic                 rx_dv,
    input wire logic                 col
);
    import pmdi_pkg::*;
    logic [1:0] up_r;
    logic       gig;
    logic       run;
    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    assign gig = (mode_i == PMDI_MODE_GMII) || (mode_i == PMDI_MODE_RGMII);
    assign run = (up_r == 2'h3);
    // Counts cycles out of reset so clock checks skip the start-up edges.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            up_r <= 2'h0;
        end else if (!run) begin
            up_r <= up_r + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////
    AST_RST_IDLE: assert property (disable iff (1'b0) srst_i |=> !rx_dv && !col && txd == 8'h00)
        else $error("link not idle in reset");
    AST_NIBBLE_HI: assert property (mode_i != PMDI_MODE_GMII |-> txd[7:4] == 4'h0 && rxd[7:4] == 4'h0)
        else $error("upper data lines used in nibble mode");
    AST_GTX_RUN: assert property (gig && run |-> gtx_clk != $past(gtx_clk))
        else $error("gigabit transmit clock stalled");
    AST_TXCLK_GIG: assert property (gig |-> !tx_clk)
        else $error("transmit clock driven outside MII");
    AST_TXCLK_100: assert property (mode_i == PMDI_MODE_MII100 && run |-> tx_clk != $past(tx_clk))
        else $error("fast MII transmit clock stalled");
    AST_TXCLK_10: assert property ($rose(tx_clk) && mode_i == PMDI_MODE_MII10 |-> tx_clk [*8] ##1 tx_clk [*2] ##1 !tx_clk)
        else $error("slow MII transmit clock half period wrong");
    AST_RXCLK_RGMII: assert property (mode_i == PMDI_MODE_RGMII |-> !rx_clk)
        else $error("receive clock pin used in RGMII");
    AST_RCK_RUN: assert property (mode_i == PMDI_MODE_RGMII && run |-> rx_dv != $past(rx_dv))
        else $error("RGMII receive clock stalled");
    AST_TXER_RGMII: assert property (mode_i == PMDI_MODE_RGMII |-> !tx_er)
        else $error("transmit error pin driven in RGMII");
    AST_COL_FULL: assert property (!half_duplex_i && !$past(half_duplex_i) |-> !col)
        else $error("collision in full duplex");
endmodule // pmdi_props

// file: tb/phy_mac_side_data_interface_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module phy_mac_side_data_interface_bench;
    import pmdi_pkg::*;
    logic       clk_i         = 1'b0;
    logic       srst_i        = 1'b1;
    pmdi_mode_e mode_i        = PMDI_MODE_MII10;
    logic       half_duplex_i = 1'b0;
    logic [9:0] drv [2]       = '{10'h000, 10'h000};
    logic [7:0] tx_data_i, rx_data_i, tx_data_o, rx_data_o;
    logic       tx_err_i, tx_valid_i, rx_err_i, rx_valid_i, tx_ready_o, rx_ready_o;
    logic       tx_valid_o, rx_valid_o, rx_err_o, col_o, col_seen;
    pmdi_sym_e  tx_sym_o;
    logic [9:0] txq [$];
    logic [8:0] rxq [$];
    logic [9:0] te;
    logic [8:0] re;
    int         err_count = 0;
    int         compares  = 0;
    int         w;
    pmdi_link_if link ();
    assign {tx_valid_i, tx_err_i, tx_data_i} = drv[1];
    assign {rx_valid_i, rx_err_i, rx_data_i} = drv[0];
    always #10 clk_i = ~clk_i;
    pmdi_phy_end pmdi_phy_end_inst (.clk_i(clk_i), .srst_i(srst_i), .mode_i(mode_i), .half_duplex_i(half_duplex_i),
        .link(link), .rx_data_i(rx_data_i), .rx_err_i(rx_err_i), .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
        .tx_data_o(tx_data_o), .tx_sym_o(tx_sym_o), .tx_valid_o(tx_valid_o));
    pmdi_mac_end pmdi_mac_end_inst (.clk_i(clk_i), .srst_i(srst_i), .mode_i(mode_i), .link(link),
        .tx_data_i(tx_data_i), .tx_err_i(tx_err_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .rx_data_o(rx_data_o), .rx_err_o(rx_err_o), .rx_valid_o(rx_valid_o), .col_o(col_o));
    pmdi_props pmdi_props_inst (.clk_i(clk_i), .srst_i(srst_i), .mode_i(mode_i), .half_duplex_i(half_duplex_i),
        .txd(link.txd), .tx_er(link.tx_er), .gtx_clk(link.gtx_clk), .tx_clk(link.tx_clk), .rx_clk(link.rx_clk),
        .rxd(link.rxd), .rx_dv(link.rx_dv), .col(link.col));
    ////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Holds the word until ready is seen; the next rising edge takes it.
    task automatic send(input bit side, input logic [7:0] d, input logic e);
        int n;
        n = 0;
        drv[side] <= {1'b1, e, d};
        do begin
            @(negedge clk_i);
            n++;
        end while ((side ? tx_ready_o : rx_ready_o) !== 1'b1 && n < 500);
        if (n >= 500) begin
            err_count++;
            summarize();
        end
        @(posedge clk_i);
    endtask
    task automatic stream(input bit side, input int cnt);
        logic [7:0] d;
        logic       e;
        for (int i = 0; i < cnt; i++) begin
            d = 8'($urandom);
            e = ($urandom % 4) == 0;
            send(side, d, e);
            if (side) txq.push_back({(e ? ((mode_i == PMDI_MODE_GMII) ? 2'h1 : 2'h3) : 2'h0), d});
            else rxq.push_back({e, d});
            if (side && e && mode_i <= PMDI_MODE_MII100) txq.push_back({2'h2, d});
        end
        drv[side] <= 10'h000;
    endtask
    ////////////////////////////////////////////////////////////
    always @(negedge clk_i) begin
        if (col_o === 1'b1) col_seen = 1'b1;
        if (tx_valid_o === 1'b1) begin
            if (txq.size() == 0) `CHK("tx_note", 1'b1, 1'b0)
            else begin
                te = txq.pop_front();
                if (te[9:8] == 2'h3) `CHK("tx_sym", 1'b1, tx_sym_o != PMDI_SYM_DATA)
                else `CHK("tx_sym", te[9:8], tx_sym_o)
                if (te[9:8] == 2'h0) `CHK("tx_data", te[7:0], tx_data_o)
            end
        end
        if (rx_valid_o === 1'b1) begin
            if (rxq.size() == 0) `CHK("rx_note", 1'b1, 1'b0)
            else begin
                re = rxq.pop_front();
                `CHK("rx_data", re[7:0], rx_data_o)
                `CHK("rx_err", re[8], rx_err_o)
            end
        end
    end
    initial begin
        void'($urandom(12398));
        for (int m = 0; m < 4; m++) begin
            mode_i        <= pmdi_mode_e'(m);
            half_duplex_i <= (m == 1);
            srst_i        <= 1'b1;
            col_seen      = 1'b0;
            repeat (12) @(posedge clk_i);
            srst_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            fork
                stream(1'b1, 12);
                stream(1'b0, 12);
            join
            w = 0;
            while ((txq.size() + rxq.size()) != 0 && w < 2000) begin
                @(posedge clk_i);
                w++;
            end
            if (w >= 2000) begin
                err_count++;
                summarize();
            end
            if (m == 1) `CHK("col", 1'b1, col_seen)
            $display("test mode %0d done", m);
        end
        summarize();
    end
endmodule // phy_mac_side_data_interface_bench
